// ==== design/rmh_cmd.sv ====
// Our own choices: the Wishbone register port and the address map.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// RL1: Type read: channel in range, else refuse
// RL2: Answer only commands addressed to us
// RL3: Diag bit set: enabled and faulty
// RL4: Firmware read returns version, ack
// RL5: Name read returns stored name
// RL6: Name set, at most six characters
// RL7: Protocol read: 10 ASCII, 11 Modbus
// RL8: Protocol set takes effect next reset
// RL9: S0 runs internal calibration, acks; the code refuses it unless the CFG par bit is set
// RL10: S1 restores factory calibration, acks; the code refuses it unless the CFG par bit is set
// RL11: Calibration enable flag one or zero
// RL12: Zero/span refused unless calibration enabled
// RL13: Host alive: silent, restart watchdog
// RL14: Status 00/04, plus 10 when enabled
// RL15: Timeout flag persists, cleared only explicitly
// RL16: Timeout count in 0.1 s steps
// RL17: Timeout set: enable plus count 01..FF
// RL18: Expiry sets flag, LED flashes until cleared
// RL19: Expiry disables watchdog, keeps count
// RL20: Default Modbus; init pin low forces ASCII
// RL21: Function 04 slave address 1..247
// RL22: Host keeps count and span legal
// RL23: Bad read: 0x84 with code 02/03
// RL24: Good read: count twice N, data ordered
// RL25: Enable mask gates the diagnostic bits

module rmh_cmd #(
  parameter int unsigned STEP_CYC   = rmh_pkg::WD_STEP_CYC,
  parameter logic [31:0] FW_VERSION = 32'h0001_0001  // Arbitrary value
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output var  logic [31:0] wb_dat_o,
  output var  logic        wb_ack_o,
  input  wire logic [5:0]  fault_i,
  input  wire logic [95:0] chan_data_i,
  input  wire logic        init_n_i,
  input  wire logic        nv_prot_i,
  input  wire logic        nv_wdflag_i,
  output var  logic        nv_prot_o,
  output var  logic        nv_wdflag_o,
  output var  logic        modbus_mode_o,
  output var  logic        led_o,
  output var  logic [3:0]  cal_req_o
);

  if (STEP_CYC < 2) begin : g_chk
    $error("rmh_cmd: STEP_CYC below 2");
  end

  // ---------------------------------------------------------------
  // State and helpers
  // ---------------------------------------------------------------
  rmh_pkg::rmh_st_t   st_r;
  rmh_pkg::rmh_st_t   st_nxt;
  rmh_pkg::rmh_cmd_t  cmd;
  rmh_pkg::rmh_resp_t rsp;
  logic               tick;
  logic               req;
  logic               wr;
  logic               wr_cmd;
  logic               to_me;
  logic               ok;
  logic               host_ok;
  logic               expire;
  logic [2:0]         nch;
  logic [7:0]         diag_mask;
  logic [15:0]        mb_start;
  logic [15:0]        mb_cnt;
  logic [16:0]        mb_end;
  logic [3:0]         idx;
  logic [8:0]         wd_nx;
  logic [31:0]        rd;
  logic [31:0]        mrg;
  logic [31:0]        mrg_en;

  function automatic logic [31:0] merge(input logic [31:0] o,
                                        input logic [31:0] w,
                                        input logic [3:0]  s);
    for (int b = 0; b < 4; b++) begin
      merge[8*b +: 8] = s[b] ? w[8*b +: 8] : o[8*b +: 8];
    end
  endfunction

  rmh_tick #(
    .CYC (STEP_CYC)
  ) u_tick (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .tick_o (tick)
  );

  assign req    = wb_cyc_i & wb_stb_i & ~st_r.ack;
  assign wr     = wb_cyc_i & wb_stb_i & wb_we_i & st_r.ack;
  assign wr_cmd = wr & (wb_adr_i == rmh_pkg::A_CMD);
  assign cmd    = rmh_pkg::rmh_cmd_t'(wb_dat_i);
  assign to_me  = (cmd.tgt == st_r.own); // RL2
  assign nch    = st_r.six ? rmh_pkg::NCH6 : rmh_pkg::NCH3;
  assign diag_mask = {2'b00, fault_i & st_r.chen[5:0]} // RL3 RL25
                   & (st_r.six ? 8'h3F : 8'h07);
  assign mb_start = st_r.arg[15:0];
  assign mb_cnt   = st_r.arg[31:16];
  assign mb_end   = {1'b0, mb_start} + {1'b0, mb_cnt};
  assign wd_nx    = {1'b0, st_r.wd_cnt} + 9'h001;

  // ---------------------------------------------------------------
  // Read mux
  // ---------------------------------------------------------------
  always_comb begin
    rd = 32'h0000_0000;
    case (wb_adr_i)
      rmh_pkg::A_CFG:  rd = {22'h00_0000, st_r.par, st_r.six, st_r.own};
      rmh_pkg::A_CHEN: rd = {24'h00_0000, st_r.chen};
      rmh_pkg::A_ARG:  rd = st_r.arg;
      rmh_pkg::A_ARG2: rd = {16'h0000, st_r.arg2};
      rmh_pkg::A_RESP: rd = st_r.resp;
      rmh_pkg::A_NLO:  rd = st_r.name[31:0]; // RL5
      rmh_pkg::A_NHI:  rd = {16'h0000, st_r.name[47:32]};
      rmh_pkg::A_FW:   rd = FW_VERSION; // RL4
      default: begin
        if (wb_adr_i >= rmh_pkg::A_MBD0 && wb_adr_i <= rmh_pkg::A_MBD5) begin
          rd = {16'h0000, st_r.mbd[16*((wb_adr_i - rmh_pkg::A_MBD0) >> 2) +: 16]};
        end
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    st_nxt     = st_r;
    st_nxt.cal = 4'h0;
    st_nxt.ack = req;
    if (req) st_nxt.dat = rd;
    rsp     = '0;
    ok      = 1'b1;
    host_ok = 1'b0;
    expire  = 1'b0;
    idx     = 4'h0;
    mrg     = merge({22'h00_0000, st_r.par, st_r.six, st_r.own}, wb_dat_i, wb_sel_i);
    mrg_en  = merge({24'h00_0000, st_r.chen}, wb_dat_i, wb_sel_i);

    // Strap catch after reset; stored protocol only read here
    st_nxt.init_s = {st_r.init_s[0], init_n_i};
    if (st_r.boot != 2'h3) st_nxt.boot = st_r.boot + 2'h1;
    if (st_r.boot == 2'h0) begin
      st_nxt.prot    = nv_prot_i;
      st_nxt.wd_flag = nv_wdflag_i; // RL15
    end
    if (st_r.boot == 2'h2) st_nxt.mode_mb = st_r.init_s[1] & st_r.prot; // RL20 RL8

    // Watchdog in 0.1 s steps
    if (tick) begin
      st_nxt.led = st_r.wd_flag & ~st_r.led; // RL18
      if (st_r.wd_en) begin
        if (wd_nx >= {1'b0, st_r.wd_to}) begin
          expire = 1'b1; // RL16
        end else begin
          st_nxt.wd_cnt = wd_nx[7:0];
        end
      end
    end
    if (!st_r.wd_flag) st_nxt.led = 1'b0; // RL18

    // Plain register writes
    if (wr) begin
      case (wb_adr_i)
        rmh_pkg::A_CFG: begin
          st_nxt.own = mrg[7:0];
          st_nxt.six = mrg[rmh_pkg::CFG_SIX];
          st_nxt.par = mrg[rmh_pkg::CFG_PAR];
        end
        rmh_pkg::A_CHEN: st_nxt.chen = mrg_en[7:0]; // RL25
        rmh_pkg::A_ARG:  st_nxt.arg  = merge(st_r.arg, wb_dat_i, wb_sel_i);
        rmh_pkg::A_ARG2: st_nxt.arg2 = wb_dat_i[15:0];
        rmh_pkg::A_TYPE: begin
          if (wb_dat_i[2:0] < rmh_pkg::NCH6) st_nxt.types[8*wb_dat_i[2:0] +: 8] = wb_dat_i[15:8];
        end
        default: ;
      endcase
    end

    // Command execution
    if (wr_cmd) begin
      rsp.done = 1'b1;
      rsp.addr = st_r.own;
      if (cmd.op == rmh_pkg::OP_HOST_OK) begin
        rsp.silent = 1'b1; // RL13
        host_ok    = 1'b1;
        st_nxt.wd_cnt = 8'h00;
      end else if (cmd.op == rmh_pkg::OP_MB_RD) begin
        if (cmd.tgt == 8'h00 || cmd.tgt > rmh_pkg::MB_ADDR_MAX || !to_me) begin
          rsp.silent = 1'b1; // RL21
        end else if (mb_start >= {13'h0000, nch}) begin
          rsp.nack = 1'b1;
          rsp.pay  = {rmh_pkg::MB_FC_ERR, rmh_pkg::EXC_START}; // RL23
        end else if (mb_cnt == 16'h0000 || mb_cnt > 16'h0006
                     || mb_end > {14'h0000, nch}) begin // RL22
          rsp.nack = 1'b1;
          rsp.pay  = {rmh_pkg::MB_FC_ERR, rmh_pkg::EXC_SPAN}; // RL23
        end else begin
          rsp.ack = 1'b1;
          rsp.pay = {rmh_pkg::MB_FC, mb_cnt[6:0], 1'b0}; // RL24
          for (int i = 0; i < 6; i++) begin
            idx = mb_start[3:0] + 4'(i);
            st_nxt.mbd[16*i +: 16] = 16'h0000;
            if (4'(i) < mb_cnt[3:0] && idx < 4'h6) begin
              st_nxt.mbd[16*i +: 16] = chan_data_i[16*idx +: 16]; // RL24
            end
          end
        end
      end else if (!to_me) begin
        rsp.silent = 1'b1; // RL2
      end else begin
        case (cmd.op)
          rmh_pkg::OP_TYPE_RD: begin
            ok = cmd.p0 < {5'h00, nch}; // RL1
            rsp.pay = {cmd.p0, st_r.types[8*cmd.p0[2:0] +: 8]};
          end
          rmh_pkg::OP_DIAG:    rsp.pay = {8'h00, diag_mask}; // RL3
          rmh_pkg::OP_FW_RD:   ok = 1'b1; // RL4
          rmh_pkg::OP_NAME_RD: ok = 1'b1; // RL5
          rmh_pkg::OP_NAME_WR: begin
            ok = cmd.p0 != 8'h00 && cmd.p0 <= rmh_pkg::NAME_MAX; // RL6
            if (ok) st_nxt.name = {st_r.arg2, st_r.arg};
          end
          rmh_pkg::OP_PROT_RD: rsp.pay = {8'h00, st_r.prot ? rmh_pkg::PROT_MB
                                                          : rmh_pkg::PROT_ASCII}; // RL7
          rmh_pkg::OP_PROT_WR: begin
            ok = cmd.p0 <= 8'h01; // RL8
            if (ok) st_nxt.prot = cmd.p0[0];
          end
          rmh_pkg::OP_CAL_INT: begin
            ok = st_r.par; // RL9
            st_nxt.cal[rmh_pkg::CAL_INT] = ok;
          end
          rmh_pkg::OP_CAL_DEF: begin
            ok = st_r.par; // RL10
            st_nxt.cal[rmh_pkg::CAL_DFLT] = ok;
          end
          rmh_pkg::OP_CAL_EN: begin
            ok = cmd.p0 <= 8'h01; // RL11
            if (ok) st_nxt.cal_en = cmd.p0[0];
          end
          rmh_pkg::OP_ZERO, rmh_pkg::OP_SPAN: begin
            ok = st_r.cal_en && cmd.p0 < {5'h00, nch}; // RL12
            st_nxt.cal[rmh_pkg::CAL_ZERO] = ok && cmd.op == rmh_pkg::OP_ZERO;
            st_nxt.cal[rmh_pkg::CAL_SPAN] = ok && cmd.op == rmh_pkg::OP_SPAN;
          end
          rmh_pkg::OP_WD_STAT: rsp.pay = {11'h000, st_r.wd_en, 1'b0, // RL14
                                          st_r.wd_flag, 2'b00};
          rmh_pkg::OP_WD_CLR:  st_nxt.wd_flag = 1'b0; // RL15
          rmh_pkg::OP_WD_RD:   rsp.pay = {7'h00, st_r.wd_en, st_r.wd_to}; // RL16
          rmh_pkg::OP_WD_WR: begin
            ok = cmd.p0 <= 8'h01 && cmd.p1 != 8'h00; // RL17
            if (ok) begin
              st_nxt.wd_en  = cmd.p0[0];
              st_nxt.wd_to  = cmd.p1;
              st_nxt.wd_cnt = 8'h00;
            end
          end
          default: ok = 1'b0;
        endcase
        rsp.ack  = ok;
        rsp.nack = ~ok;
        if (!ok) rsp.pay = 16'h0000;
      end
      st_nxt.resp = rsp;
    end

    // Expiry last so a clear in the same cycle loses
    if (expire && !host_ok) begin
      st_nxt.wd_flag = 1'b1; // RL18
      st_nxt.wd_en   = 1'b0; // RL19
      st_nxt.wd_cnt  = 8'h00;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r       <= '0;
      st_r.chen  <= rmh_pkg::CHEN_RST;
      st_r.types <= {6{rmh_pkg::TYPE_RST}};
      st_r.wd_to <= rmh_pkg::WD_TO_RST;
      st_r.boot  <= 2'h0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign wb_dat_o      = st_r.dat;
  assign wb_ack_o      = st_r.ack;
  assign nv_prot_o     = st_r.prot;
  assign nv_wdflag_o   = st_r.wd_flag;
  assign modbus_mode_o = st_r.mode_mb;
  assign led_o         = st_r.led;
  assign cal_req_o     = st_r.cal;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_wrong_addr_silent: assert property ( // RL2
    wr_cmd && !to_me && cmd.op != rmh_pkg::OP_HOST_OK |=> st_r.resp.silent)
    else $error("foreign address answered");
  a_diag_gated_mask: assert property ( // RL3
    wr_cmd && to_me && cmd.op == rmh_pkg::OP_DIAG
    |=> (st_r.resp.pay[5:0] & ~$past(st_r.chen[5:0])) == 6'h00
        && st_r.resp.pay[5:0] == ($past(fault_i) & $past(st_r.chen[5:0])
                                  & ($past(st_r.six) ? 6'h3F : 6'h07)))
    else $error("diag mask wrong");
  a_mode_held_late: assert property ( // RL8
    st_r.boot == 2'h3 |=> $stable(st_r.mode_mb))
    else $error("mode changed after start");
  a_cal_gate_off: assert property ( // RL12
    wr_cmd && to_me && !st_r.cal_en
    && (cmd.op == rmh_pkg::OP_ZERO || cmd.op == rmh_pkg::OP_SPAN)
    |=> st_r.resp.nack && st_r.cal == 4'h0)
    else $error("calibration ran while disabled");
  a_host_ok_quiet: assert property ( // RL13
    wr_cmd && cmd.op == rmh_pkg::OP_HOST_OK
    |=> st_r.resp.silent && !st_r.resp.ack && st_r.wd_cnt == 8'h00)
    else $error("host alive mishandled");
  a_wd_status_code: assert property ( // RL14
    wr_cmd && to_me && cmd.op == rmh_pkg::OP_WD_STAT
    |=> st_r.resp.pay == {11'h000, $past(st_r.wd_en), 1'b0, $past(st_r.wd_flag), 2'b00})
    else $error("status code wrong");
  a_flag_stays_set: assert property ( // RL15
    st_r.boot == 2'h3 && st_r.wd_flag
    && !(wr_cmd && to_me && cmd.op == rmh_pkg::OP_WD_CLR) |=> st_r.wd_flag)
    else $error("timeout flag lost");
  a_expiry_disables: assert property ( // RL19
    st_r.boot == 2'h3 && $rose(st_r.wd_flag) |-> !st_r.wd_en && $stable(st_r.wd_to))
    else $error("expiry kept watchdog on");
  a_led_dark_clear: assert property ( // RL18
    !st_r.wd_flag |=> !st_r.led)
    else $error("LED lit without flag");
  a_mb_start_exc: assert property ( // RL23
    wr_cmd && cmd.op == rmh_pkg::OP_MB_RD && to_me && cmd.tgt != 8'h00
    && cmd.tgt <= rmh_pkg::MB_ADDR_MAX && mb_start >= {13'h0000, nch}
    |=> st_r.resp.nack && st_r.resp.pay == {rmh_pkg::MB_FC_ERR, rmh_pkg::EXC_START})
    else $error("start exception wrong");
  a_mb_byte_count: assert property ( // RL24
    wr_cmd && cmd.op == rmh_pkg::OP_MB_RD |=> st_r.resp.ack
    |-> st_r.resp.pay[7:0] == {$past(mb_cnt[6:0]), 1'b0})
    else $error("byte count wrong");

endmodule // rmh_cmd

`default_nettype wire

// ==== design/rmh_pkg.sv ====
`default_nettype none

package rmh_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_KHZ     = 125000;
  localparam int unsigned WD_STEP_MS  = 100;
  localparam int unsigned WD_STEP_CYC = WD_STEP_MS * CLK_KHZ;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] A_CFG  = 8'h00;
  localparam logic [7:0] A_CHEN = 8'h04;
  localparam logic [7:0] A_ARG  = 8'h08;
  localparam logic [7:0] A_ARG2 = 8'h0C;
  localparam logic [7:0] A_CMD  = 8'h10;
  localparam logic [7:0] A_RESP = 8'h14;
  localparam logic [7:0] A_NLO  = 8'h18;
  localparam logic [7:0] A_NHI  = 8'h1C;
  localparam logic [7:0] A_FW   = 8'h20;
  localparam logic [7:0] A_TYPE = 8'h24;
  localparam logic [7:0] A_MBD0 = 8'h28;
  localparam logic [7:0] A_MBD5 = 8'h3C;

  // ---------------------------------------------------------------
  // Fields and reset values
  // ---------------------------------------------------------------
  localparam int unsigned CFG_SIX   = 8;
  localparam int unsigned CFG_PAR   = 9;
  localparam int unsigned CAL_ZERO  = 0;
  localparam int unsigned CAL_SPAN  = 1;
  localparam int unsigned CAL_INT   = 2;
  localparam int unsigned CAL_DFLT  = 3;
  localparam logic [7:0]  CHEN_RST  = 8'hFF;
  localparam logic [7:0]  TYPE_RST  = 8'h20;
  localparam logic [7:0]  WD_TO_RST = 8'h0A;
  localparam logic [2:0]  NCH3      = 3'h3;
  localparam logic [2:0]  NCH6      = 3'h6;
  localparam logic [7:0]  NAME_MAX  = 8'h06;

  // ---------------------------------------------------------------
  // Reply codes
  // ---------------------------------------------------------------
  localparam logic [7:0] PROT_ASCII  = 8'h10;
  localparam logic [7:0] PROT_MB     = 8'h11;
  localparam logic [7:0] MB_FC       = 8'h04;
  localparam logic [7:0] MB_FC_ERR   = 8'h84;
  localparam logic [7:0] EXC_START   = 8'h02;
  localparam logic [7:0] EXC_SPAN    = 8'h03;
  localparam logic [7:0] MB_ADDR_MAX = 8'hF7;

  typedef enum logic [4:0] {
    OP_TYPE_RD = 5'h01, OP_DIAG    = 5'h02, OP_FW_RD   = 5'h03,
    OP_NAME_RD = 5'h04, OP_NAME_WR = 5'h05, OP_PROT_RD = 5'h06,
    OP_PROT_WR = 5'h07, OP_CAL_INT = 5'h08, OP_CAL_DEF = 5'h09,
    OP_CAL_EN  = 5'h0A, OP_ZERO    = 5'h0B, OP_SPAN    = 5'h0C,
    OP_HOST_OK = 5'h0D, OP_WD_STAT = 5'h0E, OP_WD_CLR  = 5'h0F,
    OP_WD_RD   = 5'h10, OP_WD_WR   = 5'h11, OP_MB_RD   = 5'h12
  } rmh_op_t;

  typedef struct packed {
    logic [7:0] p1;
    logic [7:0] p0;
    logic [7:0] tgt;
    logic [2:0] rsv;
    logic [4:0] op;
  } rmh_cmd_t;

  typedef struct packed {
    logic [15:0] pay;
    logic [7:0]  addr;
    logic [3:0]  rsv;
    logic        silent;
    logic        nack;
    logic        ack;
    logic        done;
  } rmh_resp_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
    logic [7:0]  own;
    logic        six;
    logic        par;
    logic [7:0]  chen;
    logic [31:0] arg;
    logic [15:0] arg2;
    rmh_resp_t   resp;
    logic [47:0] name;
    logic [47:0] types;
    logic        cal_en;
    logic        prot;
    logic        mode_mb;
    logic [1:0]  boot;
    logic [1:0]  init_s;
    logic        wd_en;
    logic [7:0]  wd_to;
    logic [7:0]  wd_cnt;
    logic        wd_flag;
    logic        led;
    logic [3:0]  cal;
    logic [95:0] mbd;
  } rmh_st_t;

  typedef struct packed {
    logic [31:0] cnt;
    logic        tick;
  } rmh_tick_t;

endpackage

`default_nettype wire

// ==== design/rmh_tick.sv ====
`timescale 1ns/1ps
`default_nettype none

module rmh_tick #(
  parameter int unsigned CYC = rmh_pkg::WD_STEP_CYC
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  output var  logic tick_o
);

  rmh_pkg::rmh_tick_t st_r;
  rmh_pkg::rmh_tick_t st_nxt;

  if (CYC < 2) begin : g_chk
    $error("rmh_tick: CYC below 2");
  end

  always_comb begin
    st_nxt      = st_r;
    st_nxt.tick = 1'b0;
    if (st_r.cnt == CYC - 1) begin
      st_nxt.cnt  = 32'h0000_0000;
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.cnt = st_r.cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tick_o = st_r.tick;

endmodule // rmh_tick

`default_nettype wire

// ==== sim/rmh_nv_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// ---------------------------------------------------------------
// Nonvolatile store and measurement source
// ---------------------------------------------------------------
module rmh_nv_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        prot_wr_i,
  input  wire logic        flag_wr_i,
  output var  logic        prot_o,
  output var  logic        flag_o,
  output var  logic [95:0] chan_o
);
  logic [2:0] settle_r = 3'h0;

  initial begin
    prot_o = 1'b1;
    flag_o = 1'b0;
    for (int i = 0; i < 6; i++) begin
      chan_o[16*i +: 16] = 16'(16'h1111 * (i + 1) + 16'h0A05);
    end
  end

  // Outputs read 0 in reset, so store only once loaded
  always @(posedge clk_i) begin
    if (rst_i) begin
      settle_r <= 3'h0;
    end else if (settle_r != 3'h4) begin
      settle_r <= settle_r + 3'h1;
    end else begin
      prot_o <= prot_wr_i;
      flag_o <= flag_wr_i;
    end
  end
endmodule  // rmh_nv_model

`default_nettype wire

// ==== sim/tb_rtd_module_command_handler.sv ====
`timescale 1ns/1ps
`default_nettype none

module tb_rtd_module_command_handler;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, init_n = 1'b0;
  logic [7:0]  wb_adr = 8'h00;
  logic [31:0] wb_dat = 32'h0000_0000, wb_dat_o, rdat, rsp;
  logic        wb_ack_o, nv_prot, nv_flag, prot_o, flag_o, mb_mode, led_o;
  logic [5:0]  fault = 6'h00;
  logic [95:0] chan;
  logic [3:0]  cal_req, cal_seen = 4'h0;
  int          err_total = 0, total_checks = 0, s, c;
  logic        saw;

  always #4 clk_i = ~clk_i;
  // Cleared in reset: the pulse bus is unknown before the first edge
  always @(posedge clk_i) cal_seen <= rst_i ? 4'h0 : cal_seen | cal_req;

  rmh_cmd #(.STEP_CYC(20)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_dat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .fault_i(fault), .chan_data_i(chan),
    .init_n_i(init_n), .nv_prot_i(nv_prot), .nv_wdflag_i(nv_flag),
    .nv_prot_o(prot_o), .nv_wdflag_o(flag_o), .modbus_mode_o(mb_mode),
    .led_o(led_o), .cal_req_o(cal_req));

  rmh_nv_model nv (.clk_i(clk_i), .rst_i(rst_i), .prot_wr_i(prot_o),
    .flag_wr_i(flag_o), .prot_o(nv_prot), .flag_o(nv_flag), .chan_o(chan));

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Classic cycle: hold until ack, then release for one idle cycle
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc <= 1'b1; wb_stb <= 1'b1; wb_we <= we; wb_adr <= a; wb_dat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) chk("ack", 32'h0, 32'h1);
    rdat = wb_dat_o;
    wb_cyc <= 1'b0; wb_stb <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic cmd(input logic [4:0] op, input logic [7:0] t, p0, p1);
    wb(1'b1, rmh_pkg::A_CMD, {p1, p0, t, 3'h0, op});
    wb(1'b0, rmh_pkg::A_RESP, 32'h0);
    rsp = rdat;
  endtask

  // Own address, then silent,nack,ack,done, then payload
  task automatic rc(input string nm, input logic [3:0] nib, input logic [15:0] pay);
    chk(nm, {rsp[15:8], rsp[3:0], rsp[31:16]}, {4'h0, 8'h21, nib, pay});
  endtask

  task automatic boot(input logic pin);
    rst_i <= 1'b1; init_n <= pin;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    wb(1'b1, rmh_pkg::A_CFG, 32'h0000_0321);
  endtask

  function automatic logic [19:0] mb_exp(int st, int cn);
    if (st >= 6) return {4'h5, 16'h8402};
    if (cn == 0 || cn > 6 || st + cn > 6) return {4'h5, 16'h8403};
    return {4'h3, 8'h04, 8'(2 * cn)};
  endfunction

  initial begin
    repeat (40000) @(posedge clk_i);
    err_total++;
    final_report();
  end

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(52136));
    boot(1'b0);
    chk("mode forced", {31'h0, mb_mode}, 32'h0);
    cmd(5'h06, 8'h21, 8'h00, 8'h00); rc("prot", 4'h3, 16'h0011);
    cmd(5'h01, 8'h22, 8'h00, 8'h00); rc("other addr", 4'h9, 16'h0000);
    for (int i = 0; i < 7; i++) begin
      cmd(5'h01, 8'h21, 8'(i), 8'h00);
      rc("type", i < 6 ? 4'h3 : 4'h5, i < 6 ? {8'(i), 8'h20} : 16'h0000);
    end
    repeat (4) begin
      fault <= 6'($urandom);
      s = int'($urandom % 256);
      wb(1'b1, rmh_pkg::A_CHEN, 32'(s));
      cmd(5'h02, 8'h21, 8'h00, 8'h00);
      rc("diag", 4'h3, {8'h00, 2'b00, fault & 6'(s)});
    end
    wb(1'b0, rmh_pkg::A_FW, 32'h0);
    chk("fw", rdat, 32'h0001_0001);
    cmd(5'h03, 8'h21, 8'h00, 8'h00); rc("fw cmd", 4'h3, 16'h0000);
    wb(1'b1, rmh_pkg::A_TYPE, 32'h0000_2805);
    cmd(5'h01, 8'h21, 8'h05, 8'h00); rc("type set", 4'h3, 16'h0528);
    wb(1'b1, rmh_pkg::A_ARG, 32'h3433_3231);
    wb(1'b1, rmh_pkg::A_ARG2, 32'h0000_3635);
    cmd(5'h05, 8'h21, 8'h06, 8'h00); rc("name set", 4'h3, 16'h0000);
    wb(1'b0, rmh_pkg::A_NLO, 32'h0); chk("name lo", rdat, 32'h3433_3231);
    wb(1'b0, rmh_pkg::A_NHI, 32'h0); chk("name hi", rdat[15:0], 32'h3635);
    cmd(5'h04, 8'h21, 8'h00, 8'h00); rc("name cmd", 4'h3, 16'h0000);
    cmd(5'h07, 8'h21, 8'h00, 8'h00);
    cmd(5'h06, 8'h21, 8'h00, 8'h00); rc("prot rd0", 4'h3, 16'h0010);
    cmd(5'h07, 8'h21, 8'h01, 8'h00);
    chk("prot set", {prot_o, mb_mode}, 32'h2);
    cmd(5'h08, 8'h21, 8'h00, 8'h00); chk("s0", cal_seen, 32'h4);
    cmd(5'h09, 8'h21, 8'h00, 8'h00); chk("s1", cal_seen, 32'hC);
    cmd(5'h0B, 8'h21, 8'h00, 8'h00); rc("zero off", 4'h5, 16'h0000);
    cmd(5'h0A, 8'h21, 8'h01, 8'h00); rc("cal en", 4'h3, 16'h0000);
    cmd(5'h0B, 8'h21, 8'h00, 8'h00);
    cmd(5'h0C, 8'h21, 8'h05, 8'h00); chk("cal", cal_seen, 32'hF);
    cmd(5'h0A, 8'h21, 8'h00, 8'h00);
    cmd(5'h0C, 8'h21, 8'h00, 8'h00); rc("span off", 4'h5, 16'h0000);
    cmd(5'h11, 8'h21, 8'h01, 8'h03); rc("wd set", 4'h3, 16'h0000);
    cmd(5'h10, 8'h21, 8'h00, 8'h00); rc("wd rd", 4'h3, 16'h0103);
    repeat (12) begin
      cmd(5'h0D, 8'h77, 8'h00, 8'h00); rc("alive", 4'h9, 16'h0000);
    end
    cmd(5'h0E, 8'h21, 8'h00, 8'h00); rc("wd on", 4'h3, 16'h0010);
    saw = 1'b0;
    repeat (150) begin
      @(posedge clk_i);
      saw |= led_o;
    end
    chk("led", {31'h0, saw}, 32'h1);
    cmd(5'h0E, 8'h21, 8'h00, 8'h00); rc("wd exp", 4'h3, 16'h0004);
    cmd(5'h10, 8'h21, 8'h00, 8'h00); rc("wd keep", 4'h3, 16'h0003);
    cmd(5'h11, 8'h21, 8'h01, 8'h03);
    cmd(5'h0E, 8'h21, 8'h00, 8'h00); rc("wd on exp", 4'h3, 16'h0014);
    boot(1'b1);
    chk("mode mb", {31'h0, mb_mode}, 32'h1);
    cmd(5'h0E, 8'h21, 8'h00, 8'h00); rc("flag kept", 4'h3, 16'h0004);
    cmd(5'h0F, 8'h21, 8'h00, 8'h00);
    cmd(5'h0E, 8'h21, 8'h00, 8'h00); rc("flag clr", 4'h3, 16'h0000);
    repeat (20) @(posedge clk_i);
    chk("led off", {31'h0, led_o}, 32'h0);
    wb(1'b1, rmh_pkg::A_ARG, 32'h0001_0000);
    cmd(5'h12, 8'h00, 8'h00, 8'h00); rc("mb bcast", 4'h9, 16'h0000);
    for (int k = 0; k < 24; k++) begin
      s = k < 3 ? 6 - 2 * k : int'($urandom % 7);
      c = k < 3 ? 3 * k : int'($urandom % 8);
      wb(1'b1, rmh_pkg::A_ARG, {16'(c), 16'(s)});
      cmd(5'h12, 8'h21, 8'h00, 8'h00);
      chk("mb resp", {rsp[3:0], rsp[31:16]}, {12'h000, mb_exp(s, c)});
      if (mb_exp(s, c) >> 16 == 3) begin
        for (int i = 0; i < c; i++) begin
          wb(1'b0, 8'(rmh_pkg::A_MBD0 + 4 * i), 32'h0);
          chk("mb data", rdat[15:0], {16'h0, chan[16*(s+i) +: 16]});
        end
      end
    end
    wb(1'b1, rmh_pkg::A_CFG, 32'h0000_0021);
    fault <= 6'h3F;
    cmd(5'h01, 8'h21, 8'h03, 8'h00); rc("type 3ch", 4'h5, 16'h0000);
    cmd(5'h08, 8'h21, 8'h00, 8'h00); rc("s0 off", 4'h5, 16'h0000);
    cmd(5'h02, 8'h21, 8'h00, 8'h00); rc("diag 3ch", 4'h3, 16'h0007);
    wb(1'b1, rmh_pkg::A_ARG, 32'h0003_0001);
    cmd(5'h12, 8'h21, 8'h00, 8'h00); rc("mb 3ch", 4'h5, 16'h8403);
    final_report();
  end
endmodule  // tb_rtd_module_command_handler

`default_nettype wire
